// *** pkg/acs_pkg.sv ***
package acs_pkg;

    // Register byte offsets
    localparam logic [4:0] ACS_OFF_CTRL0 = 5'h00;
    localparam logic [4:0] ACS_OFF_CTRL1 = 5'h04;
    localparam logic [4:0] ACS_OFF_CTRL2 = 5'h08;
    localparam logic [4:0] ACS_OFF_RES_HI = 5'h0c;
    localparam logic [4:0] ACS_OFF_RES_LO = 5'h10;
    localparam logic [4:0] ACS_OFF_STATUS = 5'h14;

    // converter_control_zero fields
    localparam int ACS_C0_EN_BIT = 0;
    localparam int ACS_C0_GO_BIT = 1;
    localparam int ACS_C0_CHS_LSB = 2;
    localparam int ACS_CHS_W = 4;

    // converter_control_one fields
    localparam int ACS_C1_PCFG_LSB = 0;
    localparam int ACS_PCFG_W = 4;
    localparam int ACS_C1_VNEG_BIT = 4;
    localparam int ACS_C1_VPOS_BIT = 5;

    // converter_control_two fields
    localparam int ACS_C2_CLK_LSB = 0;
    localparam int ACS_C2_ACQ_LSB = 3;
    localparam int ACS_C2_FMT_BIT = 7;
    localparam logic [7:0] ACS_C2_MASK = 8'hbf;

    // Status fields
    localparam int ACS_ST_FLAG_BIT = 0;

    // Values after reset
    localparam logic [7:0] ACS_CTRL0_RST = 8'h00;
    localparam logic [7:0] ACS_CTRL1_RST = 8'h00;
    localparam logic [7:0] ACS_CTRL2_RST = 8'h00;
    localparam logic [2:0] ACS_ACQ_MANUAL = 3'h0;

    // Conversion clock period counts and result width
    localparam logic [4:0] ACS_HOLDOFF_TADS = 5'h03;
    localparam logic [3:0] ACS_CONV_TADS = 4'hb;
    localparam int ACS_RES_W = 10;

    typedef enum logic [2:0] {
        ACS_ST_OFF,
        ACS_ST_SAMPLE,
        ACS_ST_ACQ,
        ACS_ST_CONV,
        ACS_ST_HOLDOFF
    } acs_state_e;

endpackage : acs_pkg

// *** design/acs_tad_div.sv ***
`timescale 1ns/10ps
`default_nettype none
module acs_tad_div
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic [2:0] clk_sel_i,
    input wire logic rc_tick_i,
    input wire logic sleep_i,
    // Conversion clock enable
    output logic tad_en_o
);

    logic [5:0] cnt_ff;
    logic rc_sel;

    // Conversion clock period minus one, in system clocks
    function automatic logic [5:0] acs_div_last(input logic [2:0] sel);
        case (sel)
            3'h0: acs_div_last = 6'h01;
            3'h4: acs_div_last = 6'h03;
            3'h1: acs_div_last = 6'h07;
            3'h5: acs_div_last = 6'h0f;
            3'h2: acs_div_last = 6'h1f;
            3'h6: acs_div_last = 6'h3f;
            default: acs_div_last = 6'h01;
        endcase
    endfunction : acs_div_last

    assign rc_sel = (clk_sel_i[1:0] == 2'h3);

    always_ff @(posedge clk_i) begin
        if (rst_i || rc_sel || sleep_i) begin
            cnt_ff <= 6'h00;
        end else if (cnt_ff >= acs_div_last(clk_sel_i)) begin
            cnt_ff <= 6'h00;
        end else begin
            cnt_ff <= cnt_ff + 6'h01;
        end
    end

    // Only the RC source keeps ticking in sleep
    always_comb begin
        if (rc_sel) begin
            tad_en_o = rc_tick_i;
        end else begin
            tad_en_o = !sleep_i && (cnt_ff >= acs_div_last(clk_sel_i));
        end
    end

endmodule : acs_tad_div
`default_nettype wire

// *** design/acs_sar.sv ***
`timescale 1ns/10ps
`default_nettype none
module acs_sar
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic tad_en_i,
    input wire logic start_i,
    input wire logic abort_i,
    // Comparator, high when held sample is at or above trial level
    input wire logic comp_i,
    // Outputs
    output logic [ACS_RES_W-1:0] dac_code_o,
    output logic busy_o,
    output logic done_o,
    output logic [ACS_RES_W-1:0] result_o
);

    logic [ACS_RES_W-1:0] trial_ff;
    logic [3:0] step_ff;
    logic busy_ff;
    logic done_ff;
    logic [ACS_RES_W-1:0] result_ff;
    logic [ACS_RES_W-1:0] nxt_trial;
    logic [3:0] bit_idx;

    assign bit_idx = 4'(ACS_CONV_TADS - 4'h1 - step_ff);

    // Keep or drop the tested bit, then try the next lower one
    always_comb begin
        nxt_trial = trial_ff;
        if (!comp_i) begin
            nxt_trial[bit_idx] = 1'b0;
        end
        if (bit_idx != 4'h0) begin
            nxt_trial[bit_idx - 4'h1] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || abort_i) begin
            busy_ff <= 1'b0;
            step_ff <= 4'h0;
            trial_ff <= 10'h000;
        end else if (start_i) begin
            busy_ff <= 1'b1;
            step_ff <= 4'h0;
            trial_ff <= 10'h200;
        end else if (busy_ff && tad_en_i) begin
            step_ff <= step_ff + 4'h1;
            if (step_ff != 4'h0) begin
                trial_ff <= nxt_trial;
            end
            if (step_ff == ACS_CONV_TADS - 4'h1) begin
                busy_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= busy_ff && tad_en_i && !abort_i
                && (step_ff == ACS_CONV_TADS - 4'h1);
        end
    end

    // Partial results never reach result_o; only the final code is captured
    always_ff @(posedge clk_i) begin
        if (busy_ff && tad_en_i && !abort_i
            && (step_ff == ACS_CONV_TADS - 4'h1)) begin
            result_ff <= nxt_trial;
        end
    end

    assign dac_code_o = trial_ff;
    assign busy_o = busy_ff;
    assign done_o = done_ff;
    assign result_o = result_ff;

endmodule : acs_sar
`default_nettype wire

// *** design/acs_sequencer.sv ***
// How it works
// - Reset clears control and status registers, disables, aborts conversion
// - Completion loads result, clears start, sets flag
// - Reset leaves result registers untouched
// - Acquisition field programs 2 to 20 periods
// - Nonzero acquisition samples, then converts automatically
// - Manual mode: start stops sampling, converts
// - Acquisition field resets to manual
// - After conversion, resume sampling selected channel
// - No status exposes acquisition versus conversion
// - Three periods between conversion end and acquisition
// - Sleep conversion only with internal RC clock
// - Software selects supply or external reference
// - Result by successive approximation of held sample
// - Conversion takes eleven conversion clock periods
// - Clearing start aborts, result keeps old value
// - Compare trigger sets start only when enabled
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // System
    input wire logic trigger_i,
    input wire logic sleep_i,
    input wire logic rc_tick_i,
    // Analog front end
    input wire logic comp_i,
    output logic sample_o,
    output logic [ACS_RES_W-1:0] dac_code_o,
    output logic [ACS_CHS_W-1:0] channel_o,
    output logic [ACS_PCFG_W-1:0] port_cfg_o,
    output logic vref_pos_ext_o,
    output logic vref_neg_ext_o
);

    acs_state_e state_ff;
    acs_state_e nxt_state;
    logic [7:0] ctrl0_ff;
    logic [7:0] ctrl1_ff;
    logic [7:0] ctrl2_ff;
    logic [7:0] res_hi_ff;
    logic [7:0] res_lo_ff;
    logic flag_ff;
    logic go_ff;
    logic ack_ff;
    logic [31:0] readdata_ff;
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic tad_en;
    logic sar_start;
    logic sar_abort;
    logic sar_busy;
    logic sar_done;
    logic [ACS_RES_W-1:0] sar_result;
    logic wr_take;
    logic wr_lane0;
    logic enable;
    logic sw_go_write;
    logic sw_go_value;
    logic [2:0] acq_code;

    // Acquisition code to conversion clock periods
    function automatic logic [4:0] acs_acq_tads(input logic [2:0] code);
        case (code)
            3'h1: acs_acq_tads = 5'd2;
            3'h2: acs_acq_tads = 5'd4;
            3'h3: acs_acq_tads = 5'd6;
            3'h4: acs_acq_tads = 5'd8;
            3'h5: acs_acq_tads = 5'd12;
            3'h6: acs_acq_tads = 5'd16;
            3'h7: acs_acq_tads = 5'd20;
            default: acs_acq_tads = 5'd0;
        endcase
    endfunction : acs_acq_tads

    // Bus address decode helper for reads and writes
    function automatic logic acs_hit(input logic [4:0] addr,
                                     input logic [4:0] off);
        acs_hit = (addr == off);
    endfunction : acs_hit

    acs_tad_div u_tad_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clk_sel_i(ctrl2_ff[ACS_C2_CLK_LSB +: 3]),
        .rc_tick_i(rc_tick_i),
        .sleep_i(sleep_i),
        .tad_en_o(tad_en)
    );

    acs_sar u_sar (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tad_en_i(tad_en),
        .start_i(sar_start),
        .abort_i(sar_abort),
        .comp_i(comp_i),
        .dac_code_o(dac_code_o),
        .busy_o(sar_busy),
        .done_o(sar_done),
        .result_o(sar_result)
    );

    // Bus slave: one wait cycle on every access
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;
    assign wr_take = avs_write_i && ack_ff;
    assign wr_lane0 = wr_take && avs_byteenable_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read_i || avs_write_i) && !ack_ff;
        end
    end

    // Status holds only the flag; the sequencer phase stays hidden
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            readdata_ff <= 32'h0000_0000;
        end else if (avs_read_i && !ack_ff) begin
            if (acs_hit(avs_address_i, ACS_OFF_CTRL0)) begin
                readdata_ff <= {24'h00_0000, ctrl0_ff[7:2], go_ff,
                    ctrl0_ff[ACS_C0_EN_BIT]};
            end else if (acs_hit(avs_address_i, ACS_OFF_CTRL1)) begin
                readdata_ff <= {24'h00_0000, ctrl1_ff};
            end else if (acs_hit(avs_address_i, ACS_OFF_CTRL2)) begin
                readdata_ff <= {24'h00_0000, ctrl2_ff};
            end else if (acs_hit(avs_address_i, ACS_OFF_RES_HI)) begin
                readdata_ff <= {24'h00_0000, res_hi_ff};
            end else if (acs_hit(avs_address_i, ACS_OFF_RES_LO)) begin
                readdata_ff <= {24'h00_0000, res_lo_ff};
            end else if (acs_hit(avs_address_i, ACS_OFF_STATUS)) begin
                readdata_ff <= {31'h0000_0000, flag_ff};
            end else begin
                readdata_ff <= 32'h0000_0000;
            end
        end
    end

    assign avs_readdata_o = readdata_ff;

    // Control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl0_ff <= ACS_CTRL0_RST;
        end else if (wr_lane0 && acs_hit(avs_address_i, ACS_OFF_CTRL0)) begin
            ctrl0_ff <= {avs_writedata_i[7:2], 1'b0,
                avs_writedata_i[ACS_C0_EN_BIT]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1_ff <= ACS_CTRL1_RST;
        end else if (wr_lane0 && acs_hit(avs_address_i, ACS_OFF_CTRL1)) begin
            ctrl1_ff <= {2'h0, avs_writedata_i[5:0]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl2_ff <= ACS_CTRL2_RST;
        end else if (wr_lane0 && acs_hit(avs_address_i, ACS_OFF_CTRL2)) begin
            ctrl2_ff <= avs_writedata_i[7:0] & ACS_C2_MASK;
        end
    end

    assign enable = ctrl0_ff[ACS_C0_EN_BIT];
    assign acq_code = ctrl2_ff[ACS_C2_ACQ_LSB +: 3];
    assign channel_o = ctrl0_ff[ACS_C0_CHS_LSB +: ACS_CHS_W];
    assign port_cfg_o = ctrl1_ff[ACS_C1_PCFG_LSB +: ACS_PCFG_W];
    assign vref_pos_ext_o = ctrl1_ff[ACS_C1_VPOS_BIT];
    assign vref_neg_ext_o = ctrl1_ff[ACS_C1_VNEG_BIT];

    assign sw_go_write = wr_lane0 && acs_hit(avs_address_i, ACS_OFF_CTRL0);
    assign sw_go_value = avs_writedata_i[ACS_C0_GO_BIT]
        && avs_writedata_i[ACS_C0_EN_BIT];

    // Start bit: sets win over the completion clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            go_ff <= 1'b0;
        end else if (sw_go_write) begin
            go_ff <= sw_go_value;
        end else if (!enable) begin
            go_ff <= 1'b0;
        end else if (trigger_i) begin
            go_ff <= 1'b1;
        end else if (sar_done) begin
            go_ff <= 1'b0;
        end
    end

    // Completion flag, write one to clear; a new completion wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_ff <= 1'b0;
        end else if (sar_done) begin
            flag_ff <= 1'b1;
        end else if (wr_lane0 && acs_hit(avs_address_i, ACS_OFF_STATUS)
                     && avs_writedata_i[ACS_ST_FLAG_BIT]) begin
            flag_ff <= 1'b0;
        end
    end

    // Result pair has no reset so its power-up contents stay as found
    always_ff @(posedge clk_i) begin
        if (sar_done) begin
            if (ctrl2_ff[ACS_C2_FMT_BIT]) begin
                res_hi_ff <= {6'h00, sar_result[9:8]};
            end else begin
                res_hi_ff <= sar_result[9:2];
            end
        end else if (wr_lane0 && acs_hit(avs_address_i, ACS_OFF_RES_HI)) begin
            res_hi_ff <= avs_writedata_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sar_done) begin
            if (ctrl2_ff[ACS_C2_FMT_BIT]) begin
                res_lo_ff <= sar_result[7:0];
            end else begin
                res_lo_ff <= {sar_result[1:0], 6'h00};
            end
        end else if (wr_lane0 && acs_hit(avs_address_i, ACS_OFF_RES_LO)) begin
            res_lo_ff <= avs_writedata_i[7:0];
        end
    end

    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        sar_start = 1'b0;
        sar_abort = 1'b0;
        if (!enable) begin
            nxt_state = ACS_ST_OFF;
            sar_abort = sar_busy;
        end else begin
            case (state_ff)
                ACS_ST_OFF: begin
                    nxt_state = ACS_ST_SAMPLE;
                end
                ACS_ST_SAMPLE: begin
                    if (go_ff && acq_code == ACS_ACQ_MANUAL) begin
                        nxt_state = ACS_ST_CONV;
                        sar_start = 1'b1;
                    end else if (go_ff) begin
                        nxt_state = ACS_ST_ACQ;
                        nxt_cnt = acs_acq_tads(acq_code);
                    end
                end
                ACS_ST_ACQ: begin
                    if (!go_ff) begin
                        nxt_state = ACS_ST_SAMPLE;
                    end else if (tad_en && cnt_ff == 5'd1) begin
                        nxt_state = ACS_ST_CONV;
                        sar_start = 1'b1;
                    end else if (tad_en) begin
                        nxt_cnt = cnt_ff - 5'd1;
                    end
                end
                ACS_ST_CONV: begin
                    if (sar_done) begin
                        nxt_state = ACS_ST_HOLDOFF;
                        nxt_cnt = ACS_HOLDOFF_TADS;
                    end else if (!go_ff) begin
                        nxt_state = ACS_ST_HOLDOFF;
                        nxt_cnt = ACS_HOLDOFF_TADS;
                        sar_abort = 1'b1;
                    end
                end
                ACS_ST_HOLDOFF: begin
                    if (tad_en && cnt_ff == 5'd1) begin
                        nxt_state = ACS_ST_SAMPLE;
                    end else if (tad_en) begin
                        nxt_cnt = cnt_ff - 5'd1;
                    end
                end
                default: begin
                    nxt_state = ACS_ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ACS_ST_OFF;
            cnt_ff <= 5'd0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Hold capacitor follows the channel only while sampling
    assign sample_o = enable && (state_ff == ACS_ST_ACQ || (state_ff ==
        ACS_ST_SAMPLE && !(go_ff && acq_code == ACS_ACQ_MANUAL)));

endmodule : acs_sequencer
`default_nettype wire

// *** dv/acs_afe_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module acs_afe_model
    import acs_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Sequencer side
    input wire logic sample_i,
    input wire logic [ACS_RES_W-1:0] dac_code_i,
    // Level on the selected pin
    input wire logic [ACS_RES_W-1:0] level_i,
    // Comparator
    output logic comp_o
);
    logic [ACS_RES_W-1:0] held_ff;
    // Hold capacitor tracks the pin only while sampling
    always_ff @(posedge clk_i) begin
        if (sample_i) begin
            held_ff <= level_i;
        end
    end
    assign comp_o = (held_ff >= dac_code_i);
endmodule : acs_afe_model
`default_nettype wire

// *** dv/acs_sequencer_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer_sva
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // System
    input wire logic trigger_i,
    input wire logic sleep_i,
    input wire logic rc_tick_i,
    // Analog front end
    input wire logic comp_i,
    input wire logic sample_o,
    input wire logic [ACS_RES_W-1:0] dac_code_o,
    input wire logic [ACS_CHS_W-1:0] channel_o,
    input wire logic [ACS_PCFG_W-1:0] port_cfg_o,
    input wire logic vref_pos_ext_o,
    input wire logic vref_neg_ext_o
);
    logic wr_tk;
    logic c0_tk;
    logic en_ff;
    logic [2:0] acq_ff;
    assign wr_tk = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign c0_tk = wr_tk && avs_address_i == ACS_OFF_CTRL0;
    // Bus-side mirror; the phase itself is not visible at the ports
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_ff <= 1'b0;
        end else if (c0_tk) begin
            en_ff <= avs_writedata_i[ACS_C0_EN_BIT];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acq_ff <= ACS_ACQ_MANUAL;
        end else if (wr_tk && avs_address_i == ACS_OFF_CTRL2) begin
            acq_ff <= avs_writedata_i[ACS_C2_ACQ_LSB +: 3];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_wait;
        $rose(avs_read_i || avs_write_i) |->
            avs_waitrequest_o ##1 !avs_waitrequest_o;
    endproperty
    a_wait: assert property (p_wait) else $error("waitrequest timing");
    property p_reset;
        $fell(rst_i) |-> !sample_o && channel_o == 4'h0 && port_cfg_o == 4'h0
            && !vref_pos_ext_o && !vref_neg_ext_o;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state");
    property p_status;
        avs_read_i && !avs_waitrequest_o && avs_address_i == ACS_OFF_STATUS
            |-> avs_readdata_o[31:1] == 31'h0;
    endproperty
    a_status: assert property (p_status) else $error("status extra");
    property p_ctrl1;
        wr_tk && avs_address_i == ACS_OFF_CTRL1 |=>
            {vref_pos_ext_o, vref_neg_ext_o, port_cfg_o}
            == $past(avs_writedata_i[5:0]);
    endproperty
    a_ctrl1: assert property (p_ctrl1) else $error("reference select");
    property p_chan;
        c0_tk |=> channel_o == $past(avs_writedata_i[5:2]);
    endproperty
    a_chan: assert property (p_chan) else $error("channel select");
    property p_manual;
        c0_tk && avs_writedata_i[1:0] == 2'h3 && acq_ff == 3'h0 && sample_o
            |=> !sample_o;
    endproperty
    a_manual: assert property (p_manual) else $error("manual start");
    property p_auto;
        c0_tk && avs_writedata_i[1:0] == 2'h3 && acq_ff != 3'h0 && sample_o
            |=> sample_o [*2];
    endproperty
    a_auto: assert property (p_auto) else $error("auto acquisition");
    property p_off;
        c0_tk && !avs_writedata_i[ACS_C0_EN_BIT] |=> !sample_o [*2];
    endproperty
    a_off: assert property (p_off) else $error("disabled sampling");
    property p_trig;
        trigger_i && en_ff && acq_ff == 3'h0 && sample_o && !wr_tk
            |=> !sample_o;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger start");
    property p_low;
        $fell(sample_o) && en_ff |-> !sample_o [*4];
    endproperty
    a_low: assert property (p_low) else $error("holdoff too short");
    c_manual: cover property (p_manual);
    c_auto: cover property (p_auto);
    c_trig: cover property (p_trig);
endmodule : acs_sequencer_sva
bind acs_sequencer acs_sequencer_sva u_acs_sequencer_sva (.*);
`default_nettype wire

// *** dv/tb_adc_acquire_convert_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_adc_acquire_convert_sequencer
    import acs_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic trigger_i = 1'b0;
    logic sleep_i = 1'b0;
    logic rc_tick_i = 1'b0;
    logic [2:0] rc_cnt = 3'h0;
    logic comp_i;
    logic sample_o;
    logic [ACS_RES_W-1:0] dac_code_o;
    logic [ACS_CHS_W-1:0] channel_o;
    logic [ACS_PCFG_W-1:0] port_cfg_o;
    logic vref_pos_ext_o;
    logic vref_neg_ext_o;
    logic [ACS_RES_W-1:0] level;
    logic [15:0] e;
    int n;
    int mismatches = 0;
    int checks_done = 0;
    int acq_tad[7] = '{2, 4, 6, 8, 12, 16, 20};
    localparam int CONV_CYC = 2 * (ACS_CONV_TADS + ACS_HOLDOFF_TADS);
    always #5 clk_i = ~clk_i;
    // Free-running RC source; it keeps ticking in sleep
    always @(posedge clk_i) begin
        rc_cnt <= (rc_cnt == 3'h6) ? 3'h0 : rc_cnt + 3'h1;
        rc_tick_i <= (rc_cnt == 3'h6);
    end
    function automatic logic [9:0] lvl(input logic [3:0] ch);
        return 10'h05b + 10'h03d * {6'h0, ch};
    endfunction : lvl
    function automatic logic [15:0] pack(input logic [9:0] v, input logic rj);
        return rj ? {6'h0, v} : {v, 6'h0};
    endfunction : pack
    assign level = lvl(channel_o);
    acs_sequencer u_acs_sequencer (.*, .avs_byteenable_i(4'hf));
    acs_afe_model u_acs_afe_model (.clk_i(clk_i), .sample_i(sample_o),
        .dac_code_i(dac_code_o), .level_i(level), .comp_o(comp_i));
    task automatic conclude;
        if (mismatches == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic [4:0] a, input logic we,
                        input logic [7:0] wd, output logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, wd};
        avs_write_i <= we;
        avs_read_i <= !we;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        d = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task automatic wr(input logic [4:0] a, input logic [7:0] wd);
        logic [31:0] d;
        xfer(a, 1'b1, wd, d);
    endtask : wr
    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] d;
        xfer(a, 1'b0, 8'h00, d);
        check(d, exp);
    endtask : rdchk
    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask : do_reset
    task automatic run_len(input logic v, output int cnt);
        cnt = 0;
        @(negedge clk_i);
        while (sample_o === v && cnt < 2000) begin
            cnt++;
            @(negedge clk_i);
        end
        @(posedge clk_i);
    endtask : run_len
    task automatic in_range(input int v, input int lo, input int hi);
        check({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask : in_range
    task automatic wait_done;
        logic [31:0] d;
        for (int i = 0; i < 300; i++) begin
            xfer(ACS_OFF_CTRL0, 1'b0, 8'h00, d);
            if (d[ACS_C0_GO_BIT] === 1'b0) return;
        end
        mismatches++;
    endtask : wait_done
    // Enable, sample long enough by hand, then start
    task automatic start(input logic [3:0] ch, input logic [7:0] c2,
                         output logic [15:0] ex);
        wr(ACS_OFF_CTRL2, c2);
        wr(ACS_OFF_CTRL0, {2'h0, ch, 2'h1});
        repeat (8) @(posedge clk_i);
        wr(ACS_OFF_CTRL0, {2'h0, ch, 2'h3});
        ex = pack(lvl(ch), c2[ACS_C2_FMT_BIT]);
    endtask : start
    task automatic res_chk(input logic [15:0] ex);
        rdchk(ACS_OFF_RES_HI, {24'h0, ex[15:8]});
        rdchk(ACS_OFF_RES_LO, {24'h0, ex[7:0]});
        rdchk(ACS_OFF_STATUS, 32'h1);
        wr(ACS_OFF_STATUS, 8'h01);
        rdchk(ACS_OFF_STATUS, 32'h0);
    endtask : res_chk
    initial begin
        repeat (30000) @(posedge clk_i);
        mismatches++;
        conclude();
    end
    initial begin
        do_reset();
        rdchk(ACS_OFF_CTRL0, 32'h0);
        rdchk(ACS_OFF_CTRL1, 32'h0);
        rdchk(ACS_OFF_CTRL2, 32'h0);
        rdchk(ACS_OFF_STATUS, 32'h0);
        rdchk(5'h18, 32'h0);
        wr(ACS_OFF_RES_HI, 8'h5a);
        wr(ACS_OFF_RES_LO, 8'ha5);
        do_reset();
        rdchk(ACS_OFF_RES_HI, 32'h5a);
        rdchk(ACS_OFF_RES_LO, 32'ha5);
        wr(ACS_OFF_CTRL1, 8'h3c);
        check({26'h0, vref_pos_ext_o, vref_neg_ext_o, port_cfg_o}, 32'h3c);
        start(4'h3, 8'h80, e);
        run_len(1'b0, n);
        in_range(n, CONV_CYC - 4, CONV_CYC + 3);
        check({31'h0, sample_o}, 32'h1);
        rdchk(ACS_OFF_CTRL0, 32'h0d);
        res_chk(e);
        for (int k = 0; k < 7; k++) begin
            start(4'(k + 4), {2'h0, 3'(k + 1), 3'h0}, e);
            run_len(1'b1, n);
            in_range(n, 2 * acq_tad[k] - 3, 2 * acq_tad[k] + 1);
            run_len(1'b0, n);
            in_range(n, CONV_CYC - 4, CONV_CYC + 3);
            res_chk(e);
        end
        // Abort keeps whatever software last wrote
        wr(ACS_OFF_RES_HI, 8'h11);
        wr(ACS_OFF_RES_LO, 8'h22);
        start(4'h2, 8'h80, e);
        repeat (4) @(posedge clk_i);
        wr(ACS_OFF_CTRL0, 8'h09);
        rdchk(ACS_OFF_CTRL0, 32'h09);
        rdchk(ACS_OFF_RES_HI, 32'h11);
        rdchk(ACS_OFF_RES_LO, 32'h22);
        rdchk(ACS_OFF_STATUS, 32'h0);
        wr(ACS_OFF_CTRL0, 8'h02);
        rdchk(ACS_OFF_CTRL0, 32'h0);
        for (int k = 0; k < 2; k++) begin
            if (k == 1) wr(ACS_OFF_CTRL0, 8'h05);
            repeat (8) @(posedge clk_i);
            trigger_i <= 1'b1;
            @(posedge clk_i);
            trigger_i <= 1'b0;
            repeat (40) @(posedge clk_i);
            wait_done();
            rdchk(ACS_OFF_STATUS, {31'h0, 1'(k)});
        end
        res_chk(pack(lvl(4'h1), 1'b1));
        // Divided clock freezes in sleep, RC clock keeps converting
        sleep_i <= 1'b1;
        start(4'h6, 8'h80, e);
        repeat (40) @(posedge clk_i);
        rdchk(ACS_OFF_CTRL0, 32'h1b);
        sleep_i <= 1'b0;
        wait_done();
        res_chk(e);
        sleep_i <= 1'b1;
        start(4'h7, 8'h83, e);
        wait_done();
        res_chk(e);
        sleep_i <= 1'b0;
        start(4'h5, 8'h80, e);
        repeat (6) @(posedge clk_i);
        do_reset();
        rdchk(ACS_OFF_CTRL0, 32'h0);
        rdchk(ACS_OFF_STATUS, 32'h0);
        check({31'h0, sample_o}, 32'h0);
        conclude();
    end
endmodule : tb_adc_acquire_convert_sequencer
`default_nettype wire
